// ### adc_conversion_scan_sequencer.sv
// Conversion mode controller and scan sequencer of the converter
//
// Behaviour
// - One-shot does one conversion, doubled in length when auto-zero is set
// - After one-shot, fall to standby or shutdown per mode, state field follows
// - Mode 0x returns state to shutdown, 10 to standby, 11 keeps 11
// - Conversion starts after a start-up wait chosen by the prior state
// - Continuous single-input mode never leaves converting; without auto-zero, no internal reset
// - First result after one conversion time, then each data rate period
// - Each data ready carries a complete filtered result, no extra latency
// - Auto-zero continuous runs back-to-back one-shots, reset between each
// - Scan conversions are all one-shot, one per enabled channel
// - Scan with mode 00, 01 or 10 runs once then standby/shutdown
// - Scan with mode 11 repeats, separated by the scan cycle delay
// - Mode writes during a conversion cause no internal reset
// - Input select register is ignored while scanning
// - Each scan result raises data ready and overwrites the result
// - Scan mode whenever any enable bit set, else single-input
// - Scan starts on state field 11, which holds until done or abort
// - Enabled channels converted from bit 15 down to bit 0
// - Tagged format puts the channel tag in the four top result bits
// - Internal channels map to their fixed selector codes; all but offset also to fixed gains
// - External channels map to their selector codes, no forced gain
// - Forced gain holds while its channel is current, also in idle after a scan with enables set; gain register never changes
`timescale 1ns/10ps
`include "adc_seq_map.svh"
module adc_conversion_scan_sequencer import adc_seq_pkg::*; #(
	parameter int CONV_CYCLES       = `CONV_CYC,
	parameter int DATA_RATE_CYCLES  = `DATA_RATE_CYC,
	parameter int SETUP_SHDN_CYCLES = `SETUP_SHDN_CYC,
	parameter int SETUP_STBY_CYCLES = `SETUP_STBY_CYC
) (
	input  wire logic        clock_i,
	input  wire logic        resetn_i,
	input  wire logic        sclk_i,
	input  wire logic        cs_n_i,
	input  wire logic        mosi_i,
	input  wire logic [23:0] sample_i,
	output logic             miso_o,
	output logic             data_ready_o,
	output logic [7:0]       mux_select_o,
	output logic [2:0]       gain_o,
	output logic             filter_reset_o,
	output logic             modulator_run_o
);
	reg_bus_if bus ();

	conv_state_t st_q;
	logic [9:0]  cfg_q;
	logic [7:0]  input_select_q;
	logic [15:0] scan_en_q;
	logic [23:0] scan_delay_q;
	logic [23:0] result_q;
	logic [23:0] cnt_q;
	logic [3:0]  cur_q;
	logic        run_scan_q;
	logic        frst_q;
	logic        dr_q;
	logic [7:0]  mux_q;
	logic [2:0]  gain_q;
	logic        run_q;

	logic        cfg_wr;
	logic        start;
	logic        abort;
	logic        cont;
	logic        conv_end;
	logic        finish;
	logic        scan_now;
	logic [1:0]  ret_state;
	logic [23:0] conv_len;
	logic [4:0]  below;
	logic        pick_valid;
	logic [3:0]  pick_idx;
	logic [7:0]  pick_sel;
	logic        pick_force;
	logic [2:0]  pick_gain;

	// ==================================================================
	// Serial port and channel search
	serial_port u_port (
		.clock_i  (clock_i),
		.resetn_i (resetn_i),
		.sclk_i   (sclk_i),
		.cs_n_i   (cs_n_i),
		.mosi_i   (mosi_i),
		.miso_o   (miso_o),
		.bus      (bus.port)
	);

	// Search below the current channel while converting, else from the top
	assign below = (st_q == ST_CONVERT) ? {1'b0, cur_q} : 5'h10;

	scan_picker u_pick (
		.enable_i     (scan_en_q),
		.below_i      (below),
		.map_idx_i    (cur_q),
		.next_valid_o (pick_valid),
		.next_idx_o   (pick_idx),
		.select_o     (pick_sel),
		.force_o      (pick_force),
		.gain_o       (pick_gain)
	);

	// ==================================================================
	// Decode of host writes and of conversion ends
	assign cfg_wr    = bus.wr && bus.addr == `ADDR_CONFIG;
	assign start     = cfg_wr && bus.wdata[`CFG_STATE] == `STATE_CONVERT
	                   && st_q == ST_IDLE;
	assign abort     = cfg_wr && bus.wdata[`CFG_STATE] != `STATE_CONVERT
	                   && st_q != ST_IDLE;
	assign cont      = cfg_q[`CFG_MODE] == `MODE_CONTINUOUS;
	assign conv_len  = cfg_q[`CFG_AZ] ? 24'(2 * CONV_CYCLES) : 24'(CONV_CYCLES);
	assign conv_end  = st_q == ST_CONVERT && cnt_q == 24'h00_0001;
	// Mode is only sampled at the end, so a mid-conversion write never restarts
	assign finish    = conv_end && !cont && !(run_scan_q && pick_valid);
	assign ret_state = cfg_q[1] ? `STATE_STANDBY : `STATE_SHUTDOWN;
	assign scan_now  = (st_q == ST_IDLE) ? |scan_en_q : run_scan_q;

	// ==================================================================
	// Configuration; host write wins over the end-of-run state update
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cfg_q <= `CFG_RESET;
		end else if (cfg_wr) begin
			cfg_q <= bus.wdata[9:0];
		end else if (finish) begin
			cfg_q[`CFG_STATE] <= ret_state;
		end
	end

	// Other writable registers
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			input_select_q <= 8'h01;
			scan_en_q      <= 16'h0000;
			scan_delay_q   <= 24'h00_0000;
		end else if (bus.wr) begin
			case (bus.addr)
				`ADDR_INPUT_SELECT: input_select_q <= bus.wdata[7:0];
				`ADDR_SCAN_ENABLE:  scan_en_q      <= bus.wdata[15:0];
				`ADDR_SCAN_DELAY:   scan_delay_q   <= bus.wdata;
				default:            ;
			endcase
		end
	end

	// Read data; unmapped addresses read zero
	always_comb begin
		case (bus.addr)
			`ADDR_RESULT:       bus.rdata = result_q;
			`ADDR_CONFIG:       bus.rdata = {14'h0000, cfg_q};
			`ADDR_INPUT_SELECT: bus.rdata = {16'h0000, input_select_q};
			`ADDR_SCAN_ENABLE:  bus.rdata = {8'h00, scan_en_q};
			`ADDR_SCAN_DELAY:   bus.rdata = scan_delay_q;
			default:            bus.rdata = 24'h00_0000;
		endcase
	end

	// ==================================================================
	// Conversion state machine
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_q       <= ST_IDLE;
			cnt_q      <= 24'h00_0000;
			cur_q      <= 4'h0;
			run_scan_q <= 1'b0;
			frst_q     <= 1'b0;
		end else begin
			frst_q <= 1'b0;
			if (abort) begin
				st_q <= ST_IDLE;
			end else begin
				case (st_q)
					ST_IDLE: begin
						if (start) begin
							st_q       <= ST_STARTUP;
							run_scan_q <= |scan_en_q;
							cur_q      <= pick_idx;
							// Standby keeps the bias up, so its restart is short
							cnt_q <= cfg_q[3] ? 24'(SETUP_STBY_CYCLES)
							                  : 24'(SETUP_SHDN_CYCLES);
						end
					end
					ST_STARTUP: begin
						if (cnt_q <= 24'h00_0001) begin
							st_q   <= ST_CONVERT;
							cnt_q  <= conv_len;
							frst_q <= 1'b1;
						end else begin
							cnt_q <= cnt_q - 24'h00_0001;
						end
					end
					ST_CONVERT: begin
						if (conv_end) begin
							if (run_scan_q) begin
								if (pick_valid) begin
									cur_q  <= pick_idx;
									cnt_q  <= conv_len;
									frst_q <= 1'b1;
								end else if (cont) begin
									st_q  <= ST_SCAN_WAIT;
									cnt_q <= scan_delay_q;
								end else begin
									st_q <= ST_IDLE;
								end
							end else if (cont && cfg_q[`CFG_AZ]) begin
								cnt_q  <= conv_len;
								frst_q <= 1'b1;
							end else if (cont) begin
								// Filter keeps running: moving-average stream
								cnt_q <= 24'(DATA_RATE_CYCLES);
							end else begin
								st_q <= ST_IDLE;
							end
						end else begin
							cnt_q <= cnt_q - 24'h00_0001;
						end
					end
					ST_SCAN_WAIT: begin
						if (cnt_q == 24'h00_0000) begin
							st_q   <= ST_CONVERT;
							cur_q  <= pick_idx;
							cnt_q  <= conv_len;
							frst_q <= 1'b1;
						end else begin
							cnt_q <= cnt_q - 24'h00_0001;
						end
					end
					default: st_q <= ST_IDLE;
				endcase
			end
		end
	end

	// ==================================================================
	// Result capture at each conversion end; the filter output is final here
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			dr_q     <= 1'b0;
			result_q <= 24'h00_0000;
		end else begin
			dr_q <= conv_end && !abort;
			if (conv_end && !abort) begin
				if (run_scan_q && cfg_q[`CFG_FORMAT] == `FORMAT_TAGGED)
					result_q <= {cur_q, sample_i[19:0]};
				else
					result_q <= sample_i;
			end
		end
	end

	// ==================================================================
	// Analog controls; forced gain is local, the register is untouched
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			mux_q  <= 8'h00;
			gain_q <= `GAIN_ONE;
			run_q  <= 1'b0;
		end else begin
			mux_q  <= scan_now ? pick_sel : input_select_q;
			gain_q <= (scan_now && pick_force) ? pick_gain : cfg_q[`CFG_GAIN];
			run_q  <= st_q == ST_STARTUP || st_q == ST_CONVERT;
		end
	end

	assign data_ready_o    = dr_q;
	assign mux_select_o    = mux_q;
	assign gain_o          = gain_q;
	assign filter_reset_o  = frst_q;
	assign modulator_run_o = run_q;

	// ==================================================================
	// Checks
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!resetn_i);

	logic [23:0] age_q;
	logic        az_q;
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			age_q <= 24'h00_0000;
			az_q  <= 1'b0;
		end else if (st_q != ST_CONVERT || frst_q) begin
			age_q <= 24'h00_0001;
			az_q  <= cfg_q[`CFG_AZ];
		end else begin
			age_q <= age_q + 24'h00_0001;
		end
	end

	sequence s_setup_done;
		st_q == ST_STARTUP ##1 st_q == ST_CONVERT;
	endsequence

	sequence s_scan_step;
		dr_q && run_scan_q && st_q == ST_CONVERT;
	endsequence

	a_oneshot_length: assert property (
		(dr_q && frst_q) |-> age_q == (az_q ? 24'(2 * CONV_CYCLES) : 24'(CONV_CYCLES)))
		else $error("one-shot conversion length wrong");

	a_oneshot_return: assert property (
		(dr_q && st_q == ST_IDLE && !$past(cfg_wr)) |-> cfg_q[`CFG_STATE] == ret_state)
		else $error("state field not returned after one-shot");

	a_setup_reset: assert property (
		s_setup_done |-> frst_q && cnt_q == conv_len)
		else $error("conversion not started after setup");

	a_cont_stays: assert property (
		(st_q == ST_CONVERT && !run_scan_q && cont && !cfg_wr) |=> st_q == ST_CONVERT)
		else $error("continuous mode left converting");

	a_cont_noreset: assert property (
		(dr_q && !run_scan_q && cont && !cfg_q[`CFG_AZ] && st_q == ST_CONVERT)
		|-> !frst_q && cnt_q == 24'(DATA_RATE_CYCLES))
		else $error("continuous stream reset or mistimed");

	a_az_reset: assert property (
		(dr_q && !run_scan_q && cont && cfg_q[`CFG_AZ] && st_q == ST_CONVERT) |-> frst_q)
		else $error("auto-zero continuous missing reset");

	a_scan_hold: assert property (
		(run_scan_q && st_q != ST_IDLE && !cfg_wr && !finish)
		|=> cfg_q[`CFG_STATE] == `STATE_CONVERT)
		else $error("state field left 11 during scan");

	a_scan_order: assert property (
		s_scan_step |-> frst_q && cur_q < $past(cur_q))
		else $error("scan order not descending");

	a_scan_mux: assert property (
		(run_scan_q && st_q == ST_CONVERT) [*2] |-> mux_q == $past(pick_sel))
		else $error("selector not following scan channel");

	a_result_tag: assert property (
		(dr_q && run_scan_q && cfg_q[`CFG_FORMAT] == `FORMAT_TAGGED && !$past(cfg_wr))
		|-> result_q[23:20] == $past(cur_q))
		else $error("channel tag missing from result");

	a_gain_kept: assert property (
		!$past(cfg_wr) |-> $stable(cfg_q[`CFG_GAIN]))
		else $error("gain register changed by scan");
endmodule

// ### adc_conversion_scan_sequencer_tb_top.sv
// Self-checking bench of the conversion and scan sequencer
`timescale 1ns/10ps
`include "adc_seq_map.svh"
module adc_conversion_scan_sequencer_tb_top;
	logic        clock_i;
	logic        resetn_i;
	logic        sclk;
	logic        cs_n;
	logic        mosi;
	logic        miso;
	logic        data_ready;
	logic        filter_reset;
	logic        run;
	logic        run_p;
	logic [23:0] sample;
	logic [23:0] last_res;
	logic [7:0]  input_select_reg;
	logic [7:0]  isel;
	logic [2:0]  gain;
	logic [2:0]  pgain;
	logic [15:0] en;
	bit          quiet;
	bit          scan_on;
	bit          loop_q;
	bit          tag;
	int          q[$];
	int          gap;
	int          su = -1;
	int          exp_len;
	int          exp_su;
	int          dr_n;
	int          n0;
	int          failures;
	int          tests_run;

	adc_conversion_scan_sequencer #(
		.CONV_CYCLES      (16),
		.DATA_RATE_CYCLES (16),
		.SETUP_SHDN_CYCLES(8),
		.SETUP_STBY_CYCLES(1)
	) u_adc_conversion_scan_sequencer (
		.clock_i        (clock_i),
		.resetn_i       (resetn_i),
		.sclk_i         (sclk),
		.cs_n_i         (cs_n),
		.mosi_i         (mosi),
		.sample_i       (sample),
		.miso_o         (miso),
		.data_ready_o   (data_ready),
		.mux_select_o   (input_select_reg),
		.gain_o         (gain),
		.filter_reset_o (filter_reset),
		.modulator_run_o(run)
	);

	spi_host_model u_spi_host_model (
		.clock_i(clock_i),
		.miso_i (miso),
		.sclk_o (sclk),
		.cs_n_o (cs_n),
		.mosi_o (mosi)
	);

	// ==========
	// Checking and register helpers
	task automatic chk(input logic ok, input string m);
		tests_run++;
		if (ok !== 1'b1) begin
			failures++;
			$display("BAD %0t %s", $time, m);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [23:0] d);
		logic [23:0] v;
		u_spi_host_model.xfer(a, 1'b0, d, v);
	endtask

	task automatic rd(input logic [3:0] a, input logic [23:0] e);
		logic [23:0] v;
		u_spi_host_model.xfer(a, 1'b1, 24'h00_0000, v);
		chk(v === e, "register read");
	endtask

	task automatic wait_dr(input int n);
		for (int t = 0; t < 3000 && dr_n < n; t++) @(negedge clock_i);
		chk(dr_n >= n, "data ready missing");
	endtask

	function automatic logic [7:0] sel_of(input int c);
		case (c)
			15: return `SEL_OFFSET;
			14: return `SEL_COMMON_MODE;
			13: return `SEL_SUPPLY;
			12: return `SEL_TEMPERATURE;
			8: return `SEL_DIFF_PAIR;
			1: return `SEL_SINGLE_1;
			0: return `SEL_SINGLE_0;
			default: return `SEL_NONE;
		endcase
	endfunction

	// Forced gains only for supply, common mode and temperature
	function automatic logic [2:0] gain_of(input int c);
		if (c == 14 || c == 12) return `GAIN_ONE;
		if (c == 13) return `GAIN_THIRD;
		return pgain;
	endfunction

	// ==========
	// Model watcher: start-up, conversion length, channel order, result image
	always @(negedge clock_i) begin
		gap++;
		// Run is registered, so it rises one clock after the start is taken
		if (run === 1'b1 && run_p !== 1'b1) su = 1;
		else if (su >= 0) su++;
		if (filter_reset === 1'b1) begin
			if (exp_su > 0 && su >= 0) chk(su == exp_su, "start-up length");
			su = -1;
		end
		if (quiet) chk(filter_reset === 1'b0, "filter cleared in stream");
		if (data_ready === 1'b1) begin
			dr_n++;
			chk(gap == exp_len, "conversion length");
			last_res = sample;
			if (q.size() > 0) begin
				chk(input_select_reg === sel_of(q[0]), "scan selector");
				chk(gain === gain_of(q[0]), "scan gain");
				if (tag) last_res = {4'(q[0]), sample[19:0]};
				if (loop_q) q.push_back(q[0]);
				void'(q.pop_front());
			end else
				chk(!scan_on && input_select_reg === isel && gain === pgain, "single input");
		end
		if (data_ready === 1'b1 || filter_reset === 1'b1) gap = 0;
		run_p = run;
		sample = 24'($urandom);
	end

	// One-shot from the present state; fin is the expected config afterwards
	task automatic oneshot(input logic [23:0] cfg, fin, input int len, s);
		int k;
		isel = 8'($urandom);
		pgain = cfg[9:7];
		wr(4'h6, {16'h0000, isel});
		exp_len = len;
		exp_su = s;
		k = dr_n;
		wr(4'h1, cfg);
		wait_dr(k + 1);
		repeat (60) @(negedge clock_i);
		chk(dr_n == k + 1 && run === 1'b0, "one conversion then idle");
		rd(4'h1, fin);
		wr(4'h0, 24'hFF_FFFF);
		rd(4'h0, last_res);
	endtask

	// Continuous run; the stop write changes only the mode, mid-conversion
	task automatic stream(input logic [23:0] go, stop, input int len, s, input bit qz);
		int k;
		exp_len = len;
		exp_su = s;
		k = dr_n;
		wr(4'h1, go);
		wait_dr(k + 1);
		quiet = qz;
		wr(4'h1, stop);
		repeat (80) @(negedge clock_i);
		quiet = 1'b0;
		chk(dr_n - k >= 8 && run === 1'b0, "stream then stop");
		rd(4'h1, stop & 24'hFF_FFFB);
	endtask

	task automatic scan_go(input logic [15:0] e, input logic [23:0] cfg, input bit lp);
		wr(4'h7, {8'h00, e});
		wr(4'h6, {16'h0000, 8'($urandom)});
		q.delete();
		for (int b = 15; b >= 0; b--) if (e[b]) q.push_back(b);
		scan_on = 1'b1;
		loop_q = lp;
		tag = (cfg[6:5] == 2'b11);
		pgain = cfg[9:7];
		exp_su = 0;
		wr(4'h1, cfg);
	endtask

	// ==========
	// Clock, watchdog and verdict
	initial begin
		clock_i = 1'b0;
		forever #10 clock_i = ~clock_i;
	end

	initial begin
		repeat (60000) @(posedge clock_i);
		failures++;
		report_and_stop();
	end

	task automatic report_and_stop();
		$display("failures=%0d tests_run=%0d", failures, tests_run);
		if (failures == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// ==========
	// Main sequence
	initial begin
		resetn_i = 1'b0;
		isel = 8'h01;
		pgain = 3'h1;
		void'($urandom(40));
		repeat (20) @(negedge clock_i);
		resetn_i = 1'b1;
		repeat (4) @(negedge clock_i);
		// Selector follows the input select reset value from the first clock on
		chk(input_select_reg === 8'h01 && gain === 3'h1 && run === 1'b0 && miso === 1'b0, "reset pins");
		rd(4'h1, 24'h00_0080);
		rd(4'h6, 24'h00_0001);
		rd(4'h0, 24'h00_0000);
		wr(4'h3, 24'hFF_FFFF);
		rd(4'h3, 24'h00_0000);
		// Modes 10, 00 with auto-zero, 01, from shutdown and standby
		oneshot(24'h00_008E, 24'h00_008A, 16, 8);
		oneshot(24'h00_009C, 24'h00_0090, 32, 1);
		oneshot(24'h00_008D, 24'h00_0081, 16, 8);
		stream(24'h00_008F, 24'h00_008E, 16, 8, 1'b1);
		stream(24'h00_009F, 24'h00_009E, 32, 1, 1'b0);
		// Single scan cycle, supply and temperature always in the list
		exp_len = 16;
		en = (16'($urandom) & 16'hF103) | 16'h3000;
		n0 = dr_n;
		scan_go(en, 24'h00_02EE, 1'b0);
		wait_dr(n0 + $countones(en));
		repeat (60) @(negedge clock_i);
		chk(dr_n == n0 + $countones(en) && run === 1'b0, "one scan cycle");
		rd(4'h1, 24'h00_02EA);
		rd(4'h0, last_res);
		// Repeating scan, then abort by a non-converting state
		wr(4'h8, 24'h00_0005);
		n0 = dr_n;
		scan_go(16'h0101, 24'h00_02EF, 1'b1);
		rd(4'h1, 24'h00_02EF);
		wr(4'h1, 24'h00_02E8);
		repeat (60) @(negedge clock_i);
		chk(dr_n - n0 >= 6 && run === 1'b0, "scan cycles repeat");
		q.delete();
		scan_on = 1'b0;
		loop_q = 1'b0;
		// Enables cleared: back to single input, result carries no tag
		wr(4'h7, 24'h00_0000);
		oneshot(24'h00_02EE, 24'h00_02EA, 16, 1);
		report_and_stop();
	end
endmodule

// ### adc_seq_map.svh
// Register map, field positions, channel codes and timing counts of the sequencer
`ifndef ADC_SEQ_MAP_SVH
`define ADC_SEQ_MAP_SVH

// ==========================================================================
// Serial command byte: [5:2] address, [1:0] access type
`define CMD_WRITE         2'h2
`define CMD_READ          2'h3

// ==========================================================================
// Register addresses
`define ADDR_RESULT       4'h0
`define ADDR_CONFIG       4'h1
`define ADDR_INPUT_SELECT 4'h6
`define ADDR_SCAN_ENABLE  4'h7
`define ADDR_SCAN_DELAY   4'h8

// ==========================================================================
// Configuration register fields and reset value
`define CFG_MODE          1:0
`define CFG_STATE         3:2
`define CFG_AZ            4
`define CFG_FORMAT        6:5
`define CFG_GAIN          9:7
`define CFG_RESET         10'h0_080

// ==========================================================================
// Converter state, mode, format and gain codes
`define STATE_SHUTDOWN    2'h0
`define STATE_STANDBY     2'h2
`define STATE_CONVERT     2'h3
`define MODE_CONTINUOUS   2'h3
`define FORMAT_TAGGED     2'h3
`define GAIN_THIRD        3'h0
`define GAIN_ONE          3'h1

// ==========================================================================
// Input selector codes of the scan channels
`define SEL_OFFSET        8'h88
`define SEL_COMMON_MODE   8'hF8
`define SEL_SUPPLY        8'h98
`define SEL_TEMPERATURE   8'hDE
`define SEL_DIFF_PAIR     8'h01
`define SEL_SINGLE_1      8'h18
`define SEL_SINGLE_0      8'h08
`define SEL_NONE          8'h00

// ==========================================================================
// Times in ns and derived cycle counts at the 20 ns clock
`define CLK_PERIOD_NS     20
`define CONV_TIME_NS      20480
`define DATA_RATE_NS      20480
`define SETUP_SHDN_NS     5120
`define SETUP_STBY_NS     20
`define CONV_CYC          ((`CONV_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DATA_RATE_CYC     ((`DATA_RATE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETUP_SHDN_CYC    ((`SETUP_SHDN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETUP_STBY_CYC    ((`SETUP_STBY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### adc_seq_pkg.sv
// Types shared by the conversion sequencer modules
package adc_seq_pkg;
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_STARTUP,
		ST_CONVERT,
		ST_SCAN_WAIT
	} conv_state_t;
endpackage

// ### reg_bus_if.sv
// Register access path between the serial port and the sequencer
`timescale 1ns/10ps
interface reg_bus_if;
	logic        wr;
	logic [3:0]  addr;
	logic [23:0] wdata;
	logic [23:0] rdata;
	modport port (output wr, output addr, output wdata, input rdata);
	modport regs (input wr, input addr, input wdata, output rdata);
endinterface

// ### scan_picker.sv
// Scan channel priority search and channel code map
`timescale 1ns/10ps
`include "adc_seq_map.svh"
module scan_picker (
	input  wire logic [15:0] enable_i,
	input  wire logic [4:0]  below_i,
	input  wire logic [3:0]  map_idx_i,
	output logic             next_valid_o,
	output logic [3:0]       next_idx_o,
	output logic [7:0]       select_o,
	output logic             force_o,
	output logic [2:0]       gain_o
);
	logic [15:0] cand;

	// Channels still to come in this cycle
	for (genvar b = 0; b < 16; b++) begin : g_cand
		assign cand[b] = enable_i[b] && (5'(b) < below_i);
	end

	// Highest pending bit wins
	always_comb begin
		next_valid_o = 1'b0;
		next_idx_o   = 4'h0;
		for (int i = 0; i < 16; i++) begin
			if (cand[i]) begin
				next_valid_o = 1'b1;
				next_idx_o   = 4'(i);
			end
		end
	end

	// Selector code and forced gain; tag equals the index
	always_comb begin
		force_o = 1'b0;
		gain_o  = `GAIN_ONE;
		case (map_idx_i)
			4'hF: select_o = `SEL_OFFSET;
			4'hE: begin
				select_o = `SEL_COMMON_MODE;
				force_o  = 1'b1;
			end
			4'hD: begin
				select_o = `SEL_SUPPLY;
				force_o  = 1'b1;
				gain_o   = `GAIN_THIRD;
			end
			4'hC: begin
				select_o = `SEL_TEMPERATURE;
				force_o  = 1'b1;
			end
			4'h8: select_o = `SEL_DIFF_PAIR;
			4'h1: select_o = `SEL_SINGLE_1;
			4'h0: select_o = `SEL_SINGLE_0;
			default: select_o = `SEL_NONE;
		endcase
	end
endmodule

// ### serial_port.sv
// Serial register port, mode 0, command byte plus one 24-bit word
`timescale 1ns/10ps
`include "adc_seq_map.svh"
module serial_port (
	input  wire logic clock_i,
	input  wire logic resetn_i,
	input  wire logic sclk_i,
	input  wire logic cs_n_i,
	input  wire logic mosi_i,
	output logic      miso_o,
	reg_bus_if.port   bus
);
	logic [2:0]  sclk_q;
	logic [1:0]  csn_q;
	logic [1:0]  mosi_q;
	logic [5:0]  cnt_q;
	logic [23:0] in_q;
	logic [7:0]  cmd_q;
	logic [23:0] out_q;
	logic        wr_q;
	logic        rise;
	logic        fall;

	// ==================================================================
	// Pin synchronisers; the second stage feeds logic, sclk also its third stage for edge detection
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sclk_q <= 3'h0;
			csn_q  <= 2'h3;
			mosi_q <= 2'h0;
		end else begin
			sclk_q <= {sclk_q[1:0], sclk_i};
			csn_q  <= {csn_q[0], cs_n_i};
			mosi_q <= {mosi_q[0], mosi_i};
		end
	end

	assign rise = sclk_q[1] & ~sclk_q[2];
	assign fall = ~sclk_q[1] & sclk_q[2];

	// ==================================================================
	// Shift in on rising edges; extra bits past 32 are ignored
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cnt_q <= 6'h00;
			in_q  <= 24'h00_0000;
			cmd_q <= 8'h00;
			wr_q  <= 1'b0;
		end else begin
			wr_q <= 1'b0;
			if (csn_q[1]) begin
				cnt_q <= 6'h00;
			end else if (rise && cnt_q != 6'h20) begin
				cnt_q <= cnt_q + 6'h01;
				in_q  <= {in_q[22:0], mosi_q[1]};
				if (cnt_q == 6'h07)
					cmd_q <= {in_q[6:0], mosi_q[1]};
				if (cnt_q == 6'h1F && cmd_q[1:0] == `CMD_WRITE)
					wr_q <= 1'b1;
			end
		end
	end

	// ==================================================================
	// Read word loaded on the falling edge after the command byte
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			out_q <= 24'h00_0000;
		end else if (csn_q[1]) begin
			out_q <= 24'h00_0000;
		end else if (fall) begin
			if (cnt_q == 6'h08 && cmd_q[1:0] == `CMD_READ)
				out_q <= bus.rdata;
			else
				out_q <= {out_q[22:0], 1'b0};
		end
	end

	assign miso_o    = out_q[23];
	assign bus.wr    = wr_q;
	assign bus.addr  = cmd_q[5:2];
	// Write strobe is set on the same clock as the last shift, so the word is already whole
	assign bus.wdata = in_q;
endmodule

// ### spi_host_model.sv
// Host side model of the serial register port, mode 0 framing
`timescale 1ns/10ps
module spi_host_model (
	input  wire logic clock_i,
	input  wire logic miso_i,
	output logic      sclk_o,
	output logic      cs_n_o,
	output logic      mosi_o
);
	// ==========
	// Idle lines: serial clock parked low between frames, select high
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		mosi_o = 1'b0;
	end

	// ==========
	// One frame, command byte then 24 data bits, four clocks per serial phase.
	// Read data is sampled just before each rise, where the synchronised bit has settled.
	task automatic xfer(input logic [3:0] a, input logic rd, input logic [23:0] wd,
			output logic [23:0] rv);
		logic [31:0] sh;
		sh = {2'b00, a, 1'b1, rd, wd};
		rv = 24'h00_0000;
		@(negedge clock_i);
		cs_n_o = 1'b0;
		for (int i = 31; i >= 0; i--) begin
			mosi_o = sh[i];
			repeat (4) @(negedge clock_i);
			if (i < 24) rv[i] = miso_i;
			sclk_o = 1'b1;
			repeat (4) @(negedge clock_i);
			sclk_o = 1'b0;
		end
		repeat (4) @(negedge clock_i);
		cs_n_o = 1'b1;
		mosi_o = ~mosi_o; // Released data line must not look like the last bit
		repeat (4) @(negedge clock_i);
	endtask
endmodule
